// file: udtb_table_base.sv
// Descriptor table base address registers with an APB slave port
// Operation
// - Low page bits 7..1 are writable and give address bits 15..9.
// - Low page bit 0 is absent and always reads zero.
// - Mid page bits 7..0 are writable and give address bits 23..16.
// - High page bits 7..0 are writable and give address bits 31..24.
// - Table base is the three fields joined, bits 8..0 forced to zero.
// - Bits 31..8 of every page register read as zero.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module udtb_table_base
  import udtb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [UDTB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] table_base_addr
);
  // Access timing: a transfer is a setup cycle followed by an access cycle.
  // The register is selected and its byte captured at the setup edge, so
  // read data stands in a flop for the whole access phase.
  // A write lands at the access edge, and the assembled pointer follows one
  // edge later. The descriptor fetch logic sees that as a one-cycle lag.
  // Offsets that decode to nothing answer with an error and zero data.
  // Writes to them are dropped.
  // Only byte lane 0 carries register data, so a write whose lane 0 strobe
  // is low leaves the register as it was.
  // An access that was not preceded by its setup cycle is ignored, so a
  // glitching master cannot store a half-formed value.
  // Limitation: the pointer is not guarded against a write that lands while
  // the controller is fetching descriptors. Software must change it only
  // while the controller is idle, and write the high page last if it wants
  // the pointer to move in one step as seen from the high bits.
  // Trade-off: ready is a flop, low for one edge after reset, so the first
  // transfer after reset may see one wait state.

  // Bus phase of the cycle just ended, as seen from the slave
  typedef enum logic [1:0] {
    UDTB_PH_IDLE,
    UDTB_PH_SETUP,
    UDTB_PH_ACCESS
  } udtb_phase_t;

  udtb_sel_t sel;
  udtb_phase_t phase_q;
  udtb_phase_t phase_d;
  logic [7:0] low_val;
  logic [7:0] mid_val;
  logic [7:0] high_val;
  logic setup_now;
  logic access_now;
  logic access_legal;
  logic wr_ok;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic pready_q;
  logic pready_d;
  logic [31:0] base_q;
  logic [31:0] base_d;

  // Widen one page byte into a bus word; bits 31..8 stay zero
  function automatic logic [31:0] udtb_word_of(input logic [7:0] page);
    logic [31:0] word;
    word = UDTB_RDATA_ZERO;
    word[7:0] = page;
    return word;
  endfunction

  // Read data for a decoded register; an unmapped offset yields zero
  function automatic logic [31:0] udtb_read_mux(
    input udtb_sel_t which,
    input logic [7:0] low,
    input logic [7:0] mid,
    input logic [7:0] high
  );
    logic [31:0] word;
    word = UDTB_RDATA_ZERO;
    case (which)
      UDTB_SEL_LOW: word = udtb_word_of(low);
      UDTB_SEL_MID: word = udtb_word_of(mid);
      UDTB_SEL_HIGH: word = udtb_word_of(high);
      default: word = UDTB_RDATA_ZERO;
    endcase
    return word;
  endfunction

  // True when the decoded register exists
  function automatic logic udtb_mapped(input udtb_sel_t which);
    return which != UDTB_SEL_NONE;
  endfunction

  // Pointer assembly; the alignment bits are tied off, never stored
  function automatic logic [31:0] udtb_base_of(
    input logic [7:0] high,
    input logic [7:0] mid,
    input logic [7:0] low
  );
    return {high, mid, low[7:1], UDTB_ALIGN_ZERO};
  endfunction

  // Elaboration checks on the layout the logic below relies on
  // Bit 0 of the low page is absent: a mask that kept it would store it
  if (UDTB_LOW_WMASK[0] != 1'b0) begin : g_chk_low_mask
    $error("low page write mask must leave bit 0 out");
  end

  // The mid and high pages are implemented in full
  if ((UDTB_MID_WMASK != 8'hFF) || (UDTB_HIGH_WMASK != 8'hFF)) begin : g_chk_full_mask
    $error("mid and high page write masks must cover all eight bits");
  end

  // Reset value must lie inside the write mask, or an absent bit reads set
  if ((UDTB_PAGE_RST & ~UDTB_LOW_WMASK) != 8'h00) begin : g_chk_rst_low
    $error("low page reset value sets an absent bit");
  end

  // Offsets are compared whole, so they must be as wide as the address port
  if ($bits(UDTB_OFS_PAGE_LOW) != UDTB_ADDR_W) begin : g_chk_addr_w
    $error("register offsets and address port differ in width");
  end

  // Each register is one aligned word
  if ((UDTB_OFS_PAGE_LOW[1:0] != 2'b00) || (UDTB_OFS_PAGE_MID[1:0] != 2'b00) ||
      (UDTB_OFS_PAGE_HIGH[1:0] != 2'b00)) begin : g_chk_align
    $error("register offsets must be word aligned");
  end

  // Overlapping offsets would make two registers answer at once
  if ((UDTB_OFS_PAGE_LOW == UDTB_OFS_PAGE_MID) || (UDTB_OFS_PAGE_MID == UDTB_OFS_PAGE_HIGH) ||
      (UDTB_OFS_PAGE_LOW == UDTB_OFS_PAGE_HIGH)) begin : g_chk_distinct
    $error("register offsets must all differ");
  end

  // Full address compare; aliases fall to the unmapped select

  udtb_addr_decode u_dec (
    .addr(paddr),
    .sel(sel)
  );

  // Bus phase decode from the controls of this cycle
  assign setup_now = psel && !penable;
  assign access_now = psel && penable;

  // Phase tracker: remembers whether the next cycle may complete an access;
  // an access only stays open while ready is low
  always_comb begin
    phase_d = UDTB_PH_IDLE;
    case (phase_q)
      UDTB_PH_IDLE: begin
        if (setup_now) begin
          phase_d = UDTB_PH_SETUP;
        end
      end
      UDTB_PH_SETUP: begin
        if (setup_now) begin
          phase_d = UDTB_PH_SETUP;
        end else if (access_now && !pready_q) begin
          phase_d = UDTB_PH_ACCESS;
        end
      end
      UDTB_PH_ACCESS: begin
        if (setup_now) begin
          phase_d = UDTB_PH_SETUP;
        end else if (access_now && !pready_q) begin
          phase_d = UDTB_PH_ACCESS;
        end
      end
      default: begin
        phase_d = UDTB_PH_IDLE;
      end
    endcase
  end

  // An access counts only after its setup and only with ready high, so a
  // stray penable or the reset-release cycle can never store a value
  assign access_legal = access_now && pready_q && (phase_q != UDTB_PH_IDLE);

  // write needs lane 0 and a mapped register
  assign wr_ok = access_legal && pwrite && pstrb[0] && udtb_mapped(sel);
  assign wr_low = wr_ok && (sel == UDTB_SEL_LOW);
  assign wr_mid = wr_ok && (sel == UDTB_SEL_MID);
  assign wr_high = wr_ok && (sel == UDTB_SEL_HIGH);

  udtb_page_reg #(.WMASK(UDTB_LOW_WMASK)) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_low),
    .wr_data(pwdata[7:0]),
    .value(low_val)
  );

  udtb_page_reg #(.WMASK(UDTB_MID_WMASK)) u_mid (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_mid),
    .wr_data(pwdata[7:0]),
    .value(mid_val)
  );

  udtb_page_reg #(.WMASK(UDTB_HIGH_WMASK)) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_high),
    .wr_data(pwdata[7:0]),
    .value(high_val)
  );

  // Read data captured in setup so it stands valid through the access phase;
  // costs a flop stage but keeps prdata straight from a register
  always_comb begin
    prdata_d = UDTB_RDATA_ZERO;
    pslverr_d = 1'b0;
    if (setup_now) begin
      prdata_d = udtb_read_mux(sel, low_val, mid_val, high_val);
      // Unmapped offsets answer with an error and zero data
      pslverr_d = !udtb_mapped(sel);
    end else if (access_now) begin
      // Hold while the access lasts, including a wait before ready
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
    end
  end

  always_comb begin
    base_d = udtb_base_of(high_val, mid_val, low_val);
  end

  // Zero-wait slave: ready rises at the first edge after reset and stays up;
  // a flop rather than a tie so the output comes from a register
  always_comb begin
    pready_d = 1'b1;
  end

  // Phase tracker register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= UDTB_PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Read data and error registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= UDTB_RDATA_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Ready register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= UDTB_RDATA_ZERO;
    end else begin
      base_q <= base_d;
    end
  end

  // Every output comes straight from a flop
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = pready_q;
  assign table_base_addr = base_q;
endmodule
`default_nettype wire

// file: udtb_pkg.sv
// Package: register map, field layout and reset values of the table base block
package udtb_pkg;
  localparam int unsigned UDTB_ADDR_W = 12;
  localparam logic [11:0] UDTB_OFS_PAGE_LOW = 12'h000;
  localparam logic [11:0] UDTB_OFS_PAGE_MID = 12'h004;
  localparam logic [11:0] UDTB_OFS_PAGE_HIGH = 12'h008;
  localparam logic [7:0] UDTB_LOW_WMASK = 8'hFE;
  localparam logic [7:0] UDTB_MID_WMASK = 8'hFF;
  localparam logic [7:0] UDTB_HIGH_WMASK = 8'hFF;
  localparam logic [7:0] UDTB_PAGE_RST = 8'h00;
  localparam logic [8:0] UDTB_ALIGN_ZERO = 9'h000;
  localparam logic [31:0] UDTB_RDATA_ZERO = 32'h00000000;
  typedef enum logic [1:0] {
    UDTB_SEL_LOW,
    UDTB_SEL_MID,
    UDTB_SEL_HIGH,
    UDTB_SEL_NONE
  } udtb_sel_t;
endpackage

// file: udtb_page_reg.sv
// One 8-bit page register with a write mask of implemented bits
`timescale 1ns/100ps
`default_nettype none
module udtb_page_reg
  import udtb_pkg::*;
#(
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  logic [7:0] page_q;
  logic [7:0] page_d;

  always_comb begin
    page_d = page_q;
    if (wr_en) begin
      page_d = wr_data & WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= UDTB_PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  assign value = page_q;
endmodule
`default_nettype wire

// file: udtb_addr_decode.sv
// Address decoder mapping an APB byte address onto a page register
`timescale 1ns/100ps
`default_nettype none
module udtb_addr_decode
  import udtb_pkg::*;
(
  input wire logic [UDTB_ADDR_W-1:0] addr,
  output udtb_sel_t sel
);
  // Full compare, so aliases and unaligned addresses fall to none
  always_comb begin
    case (addr)
      UDTB_OFS_PAGE_LOW: sel = UDTB_SEL_LOW;
      UDTB_OFS_PAGE_MID: sel = UDTB_SEL_MID;
      UDTB_OFS_PAGE_HIGH: sel = UDTB_SEL_HIGH;
      default: sel = UDTB_SEL_NONE;
    endcase
  end
endmodule
`default_nettype wire

// file: udtb_asserts.sv
// Port checker for the table base block
`timescale 1ns/100ps
`default_nettype none
module udtb_asserts
  import udtb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [UDTB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [31:0] table_base_addr,
  input wire logic [3:0] pstrb
);
  // Writes need lane 0 and an accepted access
  wire rd_ph = psel && penable && !pwrite;
  wire wr_ph = psel && penable && pwrite && pstrb[0] && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_upper_zero: assert property (rd_ph |-> prdata[31:8] == 24'h000000)
    else $error("upper bits");
  chk_low_read: assert property (rd_ph && paddr == UDTB_OFS_PAGE_LOW
    |-> prdata[7:0] == {table_base_addr[15:9], 1'b0}) else $error("low read");
  chk_mid_read: assert property (rd_ph && paddr == UDTB_OFS_PAGE_MID
    |-> prdata[7:0] == table_base_addr[23:16]) else $error("mid read");
  chk_high_read: assert property (rd_ph && paddr == UDTB_OFS_PAGE_HIGH
    |-> prdata[7:0] == table_base_addr[31:24]) else $error("high read");
  chk_low_write: assert property (wr_ph && paddr == UDTB_OFS_PAGE_LOW
    |-> ##2 table_base_addr[15:9] == $past(pwdata[7:1], 2)) else $error("low write");
  chk_align_zero: assert property (table_base_addr[8:0] == 9'h000)
    else $error("align");
  chk_only_written: assert property ($changed(table_base_addr) |-> $past(wr_ph, 2))
    else $error("spurious change");
  chk_reset_clear: assert property ($rose(presetn) |-> table_base_addr == 32'h0)
    else $error("reset value");
  cover property (wr_ph);
  cover property (rd_ph && prdata[7:0] != 8'h00);
  cover property (pslverr);
endmodule
bind udtb_table_base udtb_asserts u_chk (.*);
`default_nettype wire

// file: usb_descriptor_table_base_test.sv
// Testbench for the table base block
`timescale 1ns/100ps
`default_nettype none
module usb_descriptor_table_base_test;
  import udtb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, err;
  logic [31:0] prdata, tba, rd;
  logic [31:0] wv[3] = '{32'hFFFFFF55, 32'h000000A5, 32'h1234563C};
  logic [31:0] ev[3] = '{32'h00000054, 32'h000000A5, 32'h0000003C};
  int num_errors = 0;
  int check_count = 0;
  always #2 pclk = ~pclk;
  udtb_table_base DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .table_base_addr(tba));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  // Setup may follow an access at once, so the task never drops psel
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, fill the low and high pages with stray upper bits and the mid page without, then read back
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 12'(4 * i), '0, 4'hF);
      chk("reset", rd, '0);
      xfer(1'b1, 12'(4 * i), wv[i], 4'hF);
    end
    xfer(1'b1, UDTB_OFS_PAGE_HIGH, '0, 4'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 12'(4 * i), '0, 4'hF);
      chk("readback", rd, ev[i]);
    end
    chk("base", tba, 32'h3CA55400);
    xfer(1'b0, 12'h00C, '0, 4'hF);
    chk("unmapped", {31'h0, err}, 32'h00000001);
    chk("unmapped data", rd, '0);
    xfer(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF);
    xfer(1'b0, UDTB_OFS_PAGE_LOW, '0, 4'hF);
    chk("after unmapped", tba, 32'h3CA55400);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    end_sim;
  end
  // Watchdog far beyond the few dozen cycles needed
  initial begin
    repeat (1000) @(posedge pclk);
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
